// File: core/eii_top.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] Trigger select 0: low pin requests
// [RQ2] Trigger select 1: high then low sets flag
// [RQ3] Pin sampled once per machine cycle
// [RQ4] Source holds each level six clocks
// [RQ5] Edge mode: source holds high, low cycle
// [RQ6] Edge mode: vectoring clears the flag
// [RQ7] Level mode: source holds low until taken
// [RQ8] Level mode: still low re-requests after service
// [RQ9] Level mode: flag follows pin level
// [RQ10] Enabled request wakes idle or power-down
// [RQ11] Timer control at 88h, bits 0/1
// [RQ12] Power control at 87h, idle/power-down bits
// [RQ13] Unimplemented bits: never write ones
// [RQ14] Forward only with both enables set
module eii_top
    import eii_pkg::*;
#(
    parameter int MC_CLKS = EII_MC_CLKS
) (
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        CE_I,
    input  wire logic        EXT_INT_PIN_I,
    input  wire logic        INT_ACK_I,
    output logic             INT_REQ_O,
    output logic             IDLE_O,
    output logic             POWER_DOWN_O,
    output logic             WAKE_O,
    input  wire logic [9:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [9:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I
);
    eii_ctrl_t  ctrl_q;
    logic       req_flag_q;
    logic       idle_q;
    logic       pdown_q;
    logic [7:0] pwr_gp_q;
    logic       tick;
    logic       smp_q;
    logic       prev_q;
    logic       fall_det;

    ////////////////////////////////////////////////////////////////
    // Pin sampler
    eii_sampler #(
        .MC_CLKS (MC_CLKS)
    ) u_sampler (
        .clk_i    (CLK_I),
        .rstn_i   (RSTN_I),
        .ce_i     (CE_I),
        .pin_i    (EXT_INT_PIN_I),
        .tick_o   (tick),
        .smp_q_o  (smp_q),
        .prev_q_o (prev_q)
    );

    // Edge seen between the last sample and the pin at this tick; the source must give a full cycle each side
    assign fall_det = tick && smp_q && !EXT_INT_PIN_I; // RQ2 RQ5

    ////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order
    logic       aw_held_q;
    logic       w_held_q;
    logic [9:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic       w_strb_q;
    logic       wr_fire;
    logic       bvalid_q;
    logic [1:0] bresp_q;

    // Ready only while enabled, so a frozen block never claims a handshake
    assign S_AXI_AWREADY_O = CE_I && !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY_O  = CE_I && !w_held_q && !bvalid_q;
    assign wr_fire         = CE_I && aw_held_q && w_held_q && !bvalid_q;
    assign S_AXI_BVALID_O  = bvalid_q;
    assign S_AXI_BRESP_O   = bresp_q;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 10'h000;
            w_data_q  <= 8'h00;
            w_strb_q  <= 1'b0;
        end else if (CE_I) begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_I;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_I[7:0];
                w_strb_q <= S_AXI_WSTRB_I[0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bvalid_q <= 1'b0;
            bresp_q  <= EII_RESP_OKAY;
        end else if (CE_I) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (aw_addr_q[9:2] == EII_TIC_OFS ||
                             aw_addr_q[9:2] == EII_PWR_CTRL_OFS ||
                             aw_addr_q[9:2] == EII_IEN_OFS)
                            ? EII_RESP_OKAY : EII_RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Word decode; the low two address bits are ignored
    logic wr_tic;
    logic wr_pwr;
    logic wr_ien;
    assign wr_tic = wr_fire && w_strb_q && aw_addr_q[9:2] == EII_TIC_OFS;      // RQ11
    assign wr_pwr = wr_fire && w_strb_q && aw_addr_q[9:2] == EII_PWR_CTRL_OFS; // RQ12
    assign wr_ien = wr_fire && w_strb_q && aw_addr_q[9:2] == EII_IEN_OFS;

    ////////////////////////////////////////////////////////////////
    // Control bits
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_q <= '0;
        end else if (CE_I) begin
            if (wr_tic) begin
                ctrl_q.trig_sel <= w_data_q[EII_TRIG_SEL_BIT]; // RQ11
            end
            if (wr_ien) begin
                ctrl_q.ext_en <= w_data_q[EII_EXT_EN_BIT];
                ctrl_q.glb_en <= w_data_q[EII_GLB_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Request flag
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            req_flag_q <= 1'b0;
        end else if (CE_I) begin
            if (!ctrl_q.trig_sel) begin
                if (tick) begin
                    req_flag_q <= !EXT_INT_PIN_I; // RQ1 RQ9 RQ8
                end
            end else if (fall_det) begin
                req_flag_q <= 1'b1; // RQ2
            end else if (INT_ACK_I) begin
                req_flag_q <= 1'b0; // RQ6
            end else if (wr_tic) begin
                req_flag_q <= w_data_q[EII_REQ_FLAG_BIT];
            end
        end
    end

    assign INT_REQ_O = req_flag_q && ctrl_q.ext_en && ctrl_q.glb_en; // RQ14

    ////////////////////////////////////////////////////////////////
    // Power control; an enabled request ends idle or power-down
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            idle_q   <= 1'b0;
            pdown_q  <= 1'b0;
            pwr_gp_q <= EII_PWR_RST;
        end else if (CE_I) begin
            if (INT_REQ_O) begin
                idle_q  <= 1'b0; // RQ10
                pdown_q <= 1'b0; // RQ10
            end else if (wr_pwr) begin
                idle_q  <= w_data_q[EII_IDLE_BIT];  // RQ12
                pdown_q <= w_data_q[EII_PDOWN_BIT]; // RQ12
            end
            if (wr_pwr) begin
                pwr_gp_q <= w_data_q;
            end
        end
    end

    assign IDLE_O       = idle_q;
    assign POWER_DOWN_O = pdown_q;
    assign WAKE_O       = INT_REQ_O && (idle_q || pdown_q); // RQ10

    ////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign S_AXI_ARREADY_O = CE_I && !rvalid_q;
    assign S_AXI_RVALID_O  = rvalid_q;
    assign S_AXI_RDATA_O   = rdata_q;
    assign S_AXI_RRESP_O   = rresp_q;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= EII_RESP_OKAY;
        end else if (CE_I) begin
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                rvalid_q <= 1'b1;
                rresp_q  <= EII_RESP_OKAY;
                // Unimplemented bits read as zero, software must not rely on it
                if (S_AXI_ARADDR_I[9:2] == EII_TIC_OFS) begin
                    rdata_q <= {30'h0, req_flag_q, ctrl_q.trig_sel}; // RQ11 RQ13
                end else if (S_AXI_ARADDR_I[9:2] == EII_PWR_CTRL_OFS) begin
                    rdata_q <= {24'h0, pwr_gp_q[7:2], pdown_q, idle_q}; // RQ12
                end else if (S_AXI_ARADDR_I[9:2] == EII_IEN_OFS) begin
                    rdata_q <= {24'h0, ctrl_q.glb_en, 6'h00, ctrl_q.ext_en};
                end else begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= EII_RESP_SLVERR;
                end
            end else if (S_AXI_RREADY_I) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    a_level_tracks : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ9
        (tick && !ctrl_q.trig_sel && !INT_ACK_I) |=> (req_flag_q == !$past(EXT_INT_PIN_I)))
        else $error("level flag does not track pin");
    a_edge_sets : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ2
        (fall_det && ctrl_q.trig_sel) |=> req_flag_q)
        else $error("falling edge did not set flag");
    a_edge_ack_clr : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ6
        (CE_I && ctrl_q.trig_sel && INT_ACK_I && !fall_det) |=> !req_flag_q)
        else $error("vectoring did not clear edge flag");
    a_fwd_gated : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ14
        INT_REQ_O |-> (ctrl_q.ext_en && ctrl_q.glb_en && req_flag_q))
        else $error("request forwarded while disabled");
    a_wake_clears : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ10
        (CE_I && WAKE_O) |=> (!idle_q && !pdown_q))
        else $error("enabled request did not wake");
    a_level_rereq : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ8
        (!ctrl_q.trig_sel && !EXT_INT_PIN_I && tick) ##1 (!ctrl_q.trig_sel) |-> req_flag_q)
        else $error("held low pin gave no request");
    a_low_request : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ1
        (!ctrl_q.trig_sel && tick && EXT_INT_PIN_I) |=> !req_flag_q)
        else $error("high pin left a level request");
    a_tic_readback : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ11
        wr_tic |=> (ctrl_q.trig_sel == $past(w_data_q[0])))
        else $error("trigger select write lost");
    a_level_at_tick : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ3
        (!ctrl_q.trig_sel && !tick && !wr_tic) |=> $stable(req_flag_q))
        else $error("level flag moved between samples");
    a_edge_holds : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ6
        (ctrl_q.trig_sel && req_flag_q && !(CE_I && INT_ACK_I) && !wr_tic) |=> req_flag_q)
        else $error("edge flag lost without vectoring");
    a_edge_no_set : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ2
        (ctrl_q.trig_sel && !req_flag_q && !fall_det && !wr_tic) |=> !req_flag_q)
        else $error("edge flag set without a fall");
    a_sample_take : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ3
        tick |=> (smp_q == $past(EXT_INT_PIN_I)))
        else $error("pin sample not taken at tick");
    a_sample_pair : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ2
        tick |=> (prev_q == $past(smp_q)))
        else $error("sample pair not shifted");
    a_wake_only_sleep : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ10
        WAKE_O |-> (idle_q || pdown_q))
        else $error("wake while running");
    a_idle_write : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ12
        (wr_pwr && !INT_REQ_O) |=> (idle_q == $past(w_data_q[EII_IDLE_BIT])))
        else $error("idle request write lost");
    a_pdown_write : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ12
        (wr_pwr && !INT_REQ_O) |=> (pdown_q == $past(w_data_q[EII_PDOWN_BIT])))
        else $error("power-down request write lost");

    ////////////////////////////////////////////////////////////////
    // Clock enable freezes every piece of state
    a_freeze_flag : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !CE_I |=> $stable(req_flag_q))
        else $error("flag moved while frozen");
    a_freeze_ctrl : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !CE_I |=> $stable(ctrl_q))
        else $error("control moved while frozen");
    a_freeze_pwr : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !CE_I |=> ($stable(idle_q) && $stable(pdown_q)))
        else $error("power bits moved while frozen");

    ////////////////////////////////////////////////////////////////
    // Bus handshakes: answers stand until taken
    a_bvalid_holds : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (bvalid_q && !(CE_I && S_AXI_BREADY_I)) |=> (bvalid_q && $stable(bresp_q)))
        else $error("write response dropped early");
    a_rvalid_holds : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (rvalid_q && !(CE_I && S_AXI_RREADY_I)) |=> (rvalid_q && $stable(rdata_q)))
        else $error("read data dropped early");
    a_ar_refused : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        rvalid_q |-> !S_AXI_ARREADY_O)
        else $error("read address taken while busy");
    a_aw_refused : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (aw_held_q || bvalid_q) |-> !S_AXI_AWREADY_O)
        else $error("write address taken while busy");
    a_w_refused : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (w_held_q || bvalid_q) |-> !S_AXI_WREADY_O)
        else $error("write data taken while busy");
    a_wr_resp_next : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        wr_fire |=> bvalid_q)
        else $error("write response late");
    a_rd_resp_next : assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (S_AXI_ARVALID_I && S_AXI_ARREADY_O) |=> rvalid_q)
        else $error("read response late");
    a_rd_upper_zero : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ13
        rvalid_q |-> (rdata_q[31:8] == 24'h000000))
        else $error("unused read lanes not zero");

    ////////////////////////////////////////////////////////////////
    // Independent count of clocks between samples
    logic [3:0] gap_q;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gap_q <= 4'h0;
        end else if (CE_I) begin
            if (tick) begin
                gap_q <= 4'h0;
            end else begin
                gap_q <= gap_q + 4'h1;
            end
        end
    end

    a_tick_spacing : assert property (@(posedge CLK_I) disable iff (!RSTN_I) // RQ3
        tick |-> (gap_q == 4'(MC_CLKS - 1)))
        else $error("sample spacing is not one machine cycle");
endmodule

// File: core/eii_pkg.sv
package eii_pkg;

    // Register indices; the AXI4-Lite byte address is four times the index
    localparam logic [7:0] EII_PWR_CTRL_OFS = 8'h87;
    localparam logic [7:0] EII_TIC_OFS      = 8'h88;
    localparam logic [7:0] EII_IEN_OFS      = 8'hA8;

    // Field positions
    localparam int EII_TRIG_SEL_BIT = 0;
    localparam int EII_REQ_FLAG_BIT = 1;
    localparam int EII_IDLE_BIT     = 0;
    localparam int EII_PDOWN_BIT    = 1;
    localparam int EII_EXT_EN_BIT   = 0;
    localparam int EII_GLB_EN_BIT   = 7;

    // Reset values
    localparam logic [7:0] EII_TIC_RST  = 8'h00;
    localparam logic [7:0] EII_PWR_RST  = 8'h00;
    localparam logic [7:0] EII_IEN_RST  = 8'h00;

    // Machine cycle length in CPU clocks
    localparam int EII_MC_CLKS = 6;

    // AXI response codes
    localparam logic [1:0] EII_RESP_OKAY   = 2'h0;
    localparam logic [1:0] EII_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic trig_sel;
        logic ext_en;
        logic glb_en;
    } eii_ctrl_t;

endpackage

// File: core/eii_sampler.sv
`timescale 1ns/1ps
module eii_sampler
    import eii_pkg::*;
#(
    parameter int MC_CLKS = EII_MC_CLKS
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      tick_o,
    output logic      smp_q_o,
    output logic      prev_q_o
);
    logic [3:0] cnt_q;

    ////////////////////////////////////////////////////////////////
    // One sample per machine cycle; pin held 6 clocks is always caught
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 4'h0;
        end else if (ce_i) begin
            if (cnt_q == 4'(MC_CLKS - 1)) begin
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign tick_o = ce_i && (cnt_q == 4'(MC_CLKS - 1)); // RQ3

    // Idle level high so no false edge right after reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            smp_q_o  <= 1'b1;
            prev_q_o <= 1'b1;
        end else if (tick_o) begin
            smp_q_o  <= pin_i; // RQ3
            prev_q_o <= smp_q_o;
        end
    end

    a_one_sample_mc : assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ3
        tick_o |=> !tick_o [*5])
        else $error("sample taken twice within a machine cycle");
endmodule

// File: dv/eii_pin_src.sv
`timescale 1ns/1ps
// Far-side source of the interrupt pin; idles high like a pulled-up line
module eii_pin_src
    import eii_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic lvl_i,
    output logic      pin_o
);
    int hold_q = 0;
    initial pin_o = 1'b1;
    // Never changes level before a whole machine cycle has passed
    always @(posedge clk_i) begin
        hold_q <= hold_q + 1;
        if (lvl_i !== pin_o && hold_q >= EII_MC_CLKS) begin
            pin_o  <= lvl_i;
            hold_q <= 0;
        end
    end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import eii_pkg::*;
    logic        clk = 0, rstn = 0, lvl = 1, ack = 0;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [9:0]  awa = 0, ara = 0;
    logic [7:0]  rnd = 8'h30;
    logic [31:0] wd = 0;
    wire         pin, req, idle_request, pdn, wake, awr, wrd, bv, arr, rv;
    wire  [1:0]  br, rr;
    wire  [31:0] rdd;
    wire  [2:0]  mon = {pin, wake, req};
    int          err_count = 0, checks_done = 0, n, m;
    int          mf = 0, mt = 0, me = 0, mg = 0;

    always #2.5 clk = ~clk;

    eii_top #(.MC_CLKS(EII_MC_CLKS)) u_dut (
        .CLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .EXT_INT_PIN_I(pin),
        .INT_ACK_I(ack), .INT_REQ_O(req), .IDLE_O(idle_request), .POWER_DOWN_O(pdn),
        .WAKE_O(wake), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(br),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdd),
        .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre)
    );

    eii_pin_src u_src (.clk_i(clk), .lvl_i(lvl), .pin_o(pin));

    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Address argument is the register index; the bus sees four times it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] eq, input logic [1:0] er);
        logic        ta, tw, tr, dn;
        logic [31:0] q;
        logic [1:0]  r;
        dn = 1'b0;
        @(posedge clk);
        awa <= {a, 2'b00};
        ara <= {a, 2'b00};
        wd  <= {24'h0, d};
        awv <= w;
        wv  <= w;
        bre <= w;
        arv <= !w;
        rre <= !w;
        for (int k = 0; k < 40 && !dn; k++) begin
            @(posedge clk);
            ta = awv && awr;
            tw = wv && wrd;
            tr = arv && arr;
            dn = w ? bv : rv;
            q  = rdd;
            r  = w ? br : rr;
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tr) arv <= 1'b0;
            if (dn) begin
                bre <= 1'b0;
                rre <= 1'b0;
            end
        end
        if (!dn) begin
            err_count++;
            finish_test();
        end
        chk(r, er);
        if (!w) chk(q, eq);
    endtask

    task automatic await(input int k, input logic v);
        @(negedge clk);
        for (n = 0; n < 40 && mon[k] !== v; n++) @(negedge clk);
        chk(mon[k], v);
        if (n == 40) finish_test();
        @(posedge clk);
    endtask

    task automatic mreq();
        @(negedge clk);
        chk(req, mf && me && mg);
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        xfer(0, EII_TIC_OFS, 0, EII_TIC_RST, EII_RESP_OKAY);
        xfer(0, EII_PWR_CTRL_OFS, 0, EII_PWR_RST, EII_RESP_OKAY);
        xfer(0, EII_IEN_OFS, 0, EII_IEN_RST, EII_RESP_OKAY);
        xfer(0, 8'h90, 0, 0, EII_RESP_SLVERR);
        xfer(1, 8'h90, 8'hFF, 0, EII_RESP_SLVERR);
        for (m = 0; m < 4; m++) begin
            rnd = lfsr(rnd);
            xfer(1, EII_PWR_CTRL_OFS, rnd & 8'hFC, 0, EII_RESP_OKAY);
            xfer(0, EII_PWR_CTRL_OFS, 0, rnd & 8'hFC, EII_RESP_OKAY);
        end
        // Level mode, only the individual enable set
        xfer(1, EII_IEN_OFS, 8'h01, 0, EII_RESP_OKAY);
        me = 1;
        lvl <= 1'b0;
        mf = 1;
        repeat (3 * EII_MC_CLKS) @(posedge clk);
        xfer(0, EII_TIC_OFS, 0, (mf << 1) | mt, EII_RESP_OKAY);
        mreq();
        xfer(1, EII_IEN_OFS, 8'h81, 0, EII_RESP_OKAY);
        mg = 1;
        mreq();
        // Pin stays low across the service, so a new request must follow
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2 * EII_MC_CLKS) @(posedge clk);
        mreq();
        lvl <= 1'b1;
        mf = 0;
        await(2, 1'b1);
        await(0, 1'b0);
        chk(n <= EII_MC_CLKS + 3, 1);
        // Edge mode: flag latches the fall, stays set after the pin returns high, and vectoring clears it
        xfer(1, EII_TIC_OFS, 8'h01, 0, EII_RESP_OKAY);
        mt = 1;
        mreq();
        lvl <= 1'b0;
        mf = 1;
        await(0, 1'b1);
        lvl <= 1'b1;
        repeat (3 * EII_MC_CLKS) @(posedge clk);
        mreq();
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        mf = 0;
        mreq();
        xfer(0, EII_TIC_OFS, 0, (mf << 1) | mt, EII_RESP_OKAY);
        // Idle, then power-down, each ended by a level request
        xfer(1, EII_TIC_OFS, 8'h00, 0, EII_RESP_OKAY);
        mt = 0;
        for (m = 0; m < 2; m++) begin
            xfer(1, EII_PWR_CTRL_OFS, 8'h01 << m, 0, EII_RESP_OKAY);
            chk({pdn, idle_request}, 2'h1 << m);
            lvl <= 1'b0;
            await(1, 1'b1);
            await(1, 1'b0);
            chk({pdn, idle_request}, 2'h0);
            lvl <= 1'b1;
            await(0, 1'b0);
        end
        finish_test();
    end
endmodule
